// File: dbl_pkg.sv
// package for the double-buffered converter load control block
// Function
// - eight channels, input register plus output latch
// - data read returns latch, not input
// - select zero: write goes straight to latch
// - select one: write touches input register only
// - load event from pin edge or pulse
// - writing bb00 to load register pulses
// - load event copies all selected channels together
// - gain bit: zero unity, one double
// - reference select and internal reference level
// - reset clears data, latches, gains, reference bits
// - power bit zero grounds channel output
// - reset clears power control register
// - powered-down channel still accepts register writes
package dbl_pkg;
  localparam int          NUM_CH      = 8;
  localparam int          DATA_W      = 12;
  localparam int          ADDR_W      = 4;
  // register offsets, word addresses on the plain port
  localparam logic [3:0]  ADDR_DATA0  = 4'h0;  // channels 0..7 at 0x0..0x7
  localparam logic [3:0]  ADDR_CONFIG = 4'h8;  // [7:0] sync select, [15:8] gain
  localparam logic [3:0]  ADDR_REF    = 4'h9;  // [0] source, [1] gain
  localparam logic [3:0]  ADDR_POWER  = 4'ha;  // [7:0] channel power on
  localparam logic [3:0]  ADDR_LOAD   = 4'hb;  // write-only trigger
  localparam logic [3:0]  ADDR_INPUT0 = 4'hc;  // pending input, selected by index reg
  localparam logic [3:0]  ADDR_INSEL  = 4'hd;  // index for pending input readback
  localparam logic [15:0] LOAD_MAGIC  = 16'hbb00;
  localparam int          CFG_SEL_LSB  = 0;
  localparam int          CFG_GAIN_LSB = 8;
  localparam int          REF_SRC_BIT  = 0;
  localparam int          REF_GAIN_BIT = 1;
  localparam logic [15:0] RST_ZERO    = 16'h0000;
endpackage

// File: dbl_edge_sync.sv
// two-stage synchroniser with rising-edge pulse
`timescale 1ns/100ps
module dbl_edge_sync (
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic pin_in,
  output logic      rise_pulse
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  // first stage feeds only the second; edge taken after stage two
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign rise_pulse = sync_ff & ~prev_ff;

  chk_edge_single_pulse: assert property (@(posedge ref_clk) disable iff (srst)
    rise_pulse |=> !rise_pulse) else $error("load edge pulse lasted two cycles");
endmodule

// File: dbl_load_ctrl.sv
// per-channel latch update control
`timescale 1ns/100ps
module dbl_load_ctrl #(
  parameter int DATA_W = 12
) (
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire logic              data_wr,
  input  wire logic [DATA_W-1:0] data_in,
  input  wire logic              sync_load_select,
  input  wire logic              load_event,
  output logic      [DATA_W-1:0] input_q,
  output logic      [DATA_W-1:0] latch_q
);
  logic [DATA_W-1:0] input_ff;
  logic [DATA_W-1:0] latch_ff;

  // input register always takes writes, even when powered down
  always_ff @(posedge ref_clk) begin
    if (srst) input_ff <= '0;
    else if (data_wr) input_ff <= data_in;
  end

  // latch: immediate in async mode, on the shared event in sync mode
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      latch_ff <= '0;
    end else if (!sync_load_select && data_wr) begin
      latch_ff <= data_in;
    end else if (sync_load_select && load_event) begin
      latch_ff <= input_ff;
    end
  end

  assign input_q = input_ff;
  assign latch_q = latch_ff;

  chk_async_write_latch: assert property (@(posedge ref_clk) disable iff (srst)
    (data_wr && !sync_load_select) |=> latch_ff == $past(data_in))
    else $error("async write did not reach latch");
  chk_sync_hold_latch: assert property (@(posedge ref_clk) disable iff (srst)
    (sync_load_select && !load_event) |=> $stable(latch_ff))
    else $error("sync latch moved without load event");
  chk_sync_event_copy: assert property (@(posedge ref_clk) disable iff (srst)
    (sync_load_select && load_event) |=> latch_ff == $past(input_ff))
    else $error("load event did not copy input");
endmodule

// File: dbl_buffer_load.sv
// top: register port, load triggers and eight double-buffered channels
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/100ps
module dbl_buffer_load #(
  parameter int NUM_CH = dbl_pkg::NUM_CH,
  parameter int DATA_W = dbl_pkg::DATA_W
) (
  input  wire logic                         ref_clk,
  input  wire logic                         srst,
  input  wire logic [dbl_pkg::ADDR_W-1:0]   addr,
  input  wire logic [15:0]                  wdata,
  input  wire logic                         wr_en,
  input  wire logic                         rd_en,
  output logic      [15:0]                  rdata,
  input  wire logic                         ext_load_pin,
  output logic      [NUM_CH*DATA_W-1:0]     ch_code,
  output logic      [NUM_CH-1:0]            output_gain_select,
  output logic      [NUM_CH-1:0]            channel_power_on,
  output logic                              ref_source_select,
  output logic                              ref_gain_select,
  output logic                              int_ref_high
);
  logic [NUM_CH-1:0]        sync_sel_ff;
  logic [NUM_CH-1:0]        gain_ff;
  logic [NUM_CH-1:0]        pwr_ff;
  logic                     ref_src_ff;
  logic                     ref_gain_ff;
  logic                     int_ref_ff;
  logic [2:0]               insel_ff;
  logic                     int_load_pulse;
  logic                     ext_rise;
  logic                     load_event;
  logic [NUM_CH-1:0]        data_wr;
  logic [DATA_W-1:0]        in_q  [NUM_CH];
  logic [DATA_W-1:0]        lat_q [NUM_CH];
  logic [NUM_CH*DATA_W-1:0] code_ff;
  logic [15:0]              rdata_ff;
  logic [15:0]              nxt_rdata;

  // decoded write to the register at a fixed offset
  // the strobe is an argument so a continuous assign sees it change
  function automatic logic wr_hit(input logic we, input logic [3:0] a, input logic [3:0] off);
    return we && (a == off);
  endfunction

  // the pin edge is synchronised before it may touch any latch
  dbl_edge_sync dbl_edge_sync_inst (
    .ref_clk    (ref_clk),
    .srst       (srst),
    .pin_in     (ext_load_pin),
    .rise_pulse (ext_rise)
  );

  // magic value only; other writes to the load register are ignored
  assign int_load_pulse = wr_hit(wr_en, addr, dbl_pkg::ADDR_LOAD)
                          && (wdata == dbl_pkg::LOAD_MAGIC);
  assign load_event     = int_load_pulse | ext_rise;

  // a load event needs a cause; a spurious one would move every synced latch
  chk_load_needs_cause: assert property (
    @(posedge ref_clk) disable iff (srst)
    (!ext_rise && !(wr_en && addr == dbl_pkg::ADDR_LOAD)) |-> !load_event)
    else $error("load event without pin edge or load write");

  chk_pulse_needs_magic: assert property (
    @(posedge ref_clk) disable iff (srst)
    int_load_pulse |-> (wr_en && addr == dbl_pkg::ADDR_LOAD && wdata == dbl_pkg::LOAD_MAGIC))
    else $error("internal load pulse without the magic write");

  // a quiet pin must never look like an edge after the synchroniser
  chk_pin_low_quiet: assert property (
    @(posedge ref_clk) disable iff (srst)
    (!ext_load_pin [*3]) |-> !ext_rise)
    else $error("edge pulse while the load pin stayed low");

  // channels 0..7 are the low offsets; one instance per channel
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    assign data_wr[i] = wr_en && addr[3] == 1'b0 && addr[2:0] == 3'(i);
    dbl_load_ctrl #(.DATA_W(DATA_W)) dbl_load_ctrl_inst (
      .ref_clk          (ref_clk),
      .srst             (srst),
      .data_wr          (data_wr[i]),
      .data_in          (wdata[DATA_W-1:0]),
      .sync_load_select (sync_sel_ff[i]),
      .load_event       (load_event),
      .input_q          (in_q[i]),
      .latch_q          (lat_q[i])
    );

    // per-channel checks: one set per latch, so a wrong index shows at once
    chk_ch_read_latch: assert property (
      @(posedge ref_clk) disable iff (srst)
      (rd_en && addr == {1'b0, 3'(i)}) |=> rdata == {4'h0, $past(lat_q[i])})
      else $error("channel read did not return its latch");

    chk_ch_code_follow: assert property (
      @(posedge ref_clk) disable iff (srst)
      pwr_ff[i] |=> ch_code[i*DATA_W +: DATA_W] == $past(lat_q[i]))
      else $error("powered channel code differs from its latch");

    chk_ch_code_down: assert property (
      @(posedge ref_clk) disable iff (srst)
      !pwr_ff[i] |=> ch_code[i*DATA_W +: DATA_W] == '0)
      else $error("powered-down channel code not zero");

    // writes must land in the input register even while powered down
    chk_ch_input_write: assert property (
      @(posedge ref_clk) disable iff (srst)
      data_wr[i] |=> in_q[i] == $past(wdata[DATA_W-1:0]))
      else $error("channel write missed its input register");

    chk_ch_sync_hold: assert property (
      @(posedge ref_clk) disable iff (srst)
      (data_wr[i] && sync_sel_ff[i] && !load_event) |=> $stable(lat_q[i]))
      else $error("synced channel latch moved on a plain write");

    chk_ch_sync_load: assert property (
      @(posedge ref_clk) disable iff (srst)
      (load_event && sync_sel_ff[i]) |=> lat_q[i] == $past(in_q[i]))
      else $error("synced channel missed the shared load");

    chk_ch_reset_clear: assert property (
      @(posedge ref_clk)
      srst |=> (in_q[i] == '0 && lat_q[i] == '0))
      else $error("reset left channel registers set");
  end

  // configuration register: sync selects and per-channel gain
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sync_sel_ff <= '0;
      gain_ff     <= '0;
    end else if (wr_hit(wr_en, addr, dbl_pkg::ADDR_CONFIG)) begin
      sync_sel_ff <= wdata[dbl_pkg::CFG_SEL_LSB +: NUM_CH];
      gain_ff     <= wdata[dbl_pkg::CFG_GAIN_LSB +: NUM_CH];
    end
  end

  // config moves only on its own write; a stray change would retime loads
  chk_cfg_write_lands: assert property (
    @(posedge ref_clk) disable iff (srst)
    (wr_en && addr == dbl_pkg::ADDR_CONFIG) |=> {gain_ff, sync_sel_ff} == $past(wdata))
    else $error("config write did not land");

  chk_cfg_hold: assert property (
    @(posedge ref_clk) disable iff (srst)
    !(wr_en && addr == dbl_pkg::ADDR_CONFIG) |=> ($stable(gain_ff) && $stable(sync_sel_ff)))
    else $error("config changed without a write");

  // reference bits
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ref_src_ff  <= 1'b0;
      ref_gain_ff <= 1'b0;
      int_ref_ff  <= 1'b0;
    end else if (wr_hit(wr_en, addr, dbl_pkg::ADDR_REF)) begin
      ref_src_ff  <= wdata[dbl_pkg::REF_SRC_BIT];
      ref_gain_ff <= wdata[dbl_pkg::REF_GAIN_BIT];
      // decoded at the write so the pin leaves a flop in step with the bits
      int_ref_ff  <= ~wdata[dbl_pkg::REF_SRC_BIT] & wdata[dbl_pkg::REF_GAIN_BIT];
    end
  end

  // reference bits: write lands, holds otherwise, level flag agrees
  chk_ref_write_lands: assert property (
    @(posedge ref_clk) disable iff (srst)
    (wr_en && addr == dbl_pkg::ADDR_REF) |=>
      (ref_src_ff == $past(wdata[dbl_pkg::REF_SRC_BIT])
       && ref_gain_ff == $past(wdata[dbl_pkg::REF_GAIN_BIT])))
    else $error("reference write did not land");

  chk_ref_hold: assert property (
    @(posedge ref_clk) disable iff (srst)
    !(wr_en && addr == dbl_pkg::ADDR_REF) |=> ($stable(ref_src_ff) && $stable(ref_gain_ff)))
    else $error("reference bits changed without a write");

  // external source must ignore the gain bit in the level flag
  chk_int_ref_level: assert property (
    @(posedge ref_clk) disable iff (srst)
    int_ref_ff == (~ref_src_ff & ref_gain_ff))
    else $error("internal reference level flag disagrees with bits");

  chk_ref_reset: assert property (
    @(posedge ref_clk)
    srst |=> !int_ref_ff)
    else $error("reset left the high reference level set");

  // power control starts all channels down
  always_ff @(posedge ref_clk) begin
    if (srst) pwr_ff <= '0;
    else if (wr_hit(wr_en, addr, dbl_pkg::ADDR_POWER)) pwr_ff <= wdata[NUM_CH-1:0];
  end

  // power bits move only on their own write; nothing else may wake a channel
  chk_pwr_write_lands: assert property (
    @(posedge ref_clk) disable iff (srst)
    (wr_en && addr == dbl_pkg::ADDR_POWER) |=> pwr_ff == $past(wdata[NUM_CH-1:0]))
    else $error("power write did not land");

  chk_pwr_hold: assert property (
    @(posedge ref_clk) disable iff (srst)
    !(wr_en && addr == dbl_pkg::ADDR_POWER) |=> $stable(pwr_ff))
    else $error("power bits changed without a write");

  // index for pending-input readback, a debug view
  always_ff @(posedge ref_clk) begin
    if (srst) insel_ff <= '0;
    else if (wr_hit(wr_en, addr, dbl_pkg::ADDR_INSEL)) insel_ff <= wdata[2:0];
  end

  chk_insel_write: assert property (
    @(posedge ref_clk) disable iff (srst)
    (wr_en && addr == dbl_pkg::ADDR_INSEL) |=> insel_ff == $past(wdata[2:0]))
    else $error("pending input index write did not land");

  // read mux; unmapped and load offsets read zero
  always_comb begin
    nxt_rdata = dbl_pkg::RST_ZERO;
    case (addr)
      dbl_pkg::ADDR_CONFIG: nxt_rdata = {gain_ff, sync_sel_ff};
      dbl_pkg::ADDR_REF:    nxt_rdata = {14'h0, ref_gain_ff, ref_src_ff};
      dbl_pkg::ADDR_POWER:  nxt_rdata = {8'h00, pwr_ff};
      dbl_pkg::ADDR_INPUT0: nxt_rdata = {4'h0, in_q[insel_ff]};
      dbl_pkg::ADDR_INSEL:  nxt_rdata = {13'h0, insel_ff};
      default: begin
        if (addr[3] == 1'b0) nxt_rdata = {4'h0, lat_q[addr[2:0]]};
      end
    endcase
  end

  // read data stands the cycle after the strobe only
  always_ff @(posedge ref_clk) begin
    if (srst) rdata_ff <= dbl_pkg::RST_ZERO;
    else if (rd_en) rdata_ff <= nxt_rdata;
    else rdata_ff <= dbl_pkg::RST_ZERO;
  end

  // readback of every mapped register but the index, one cycle after the strobe
  chk_read_config: assert property (
    @(posedge ref_clk) disable iff (srst)
    (rd_en && addr == dbl_pkg::ADDR_CONFIG) |=> rdata == $past({gain_ff, sync_sel_ff}))
    else $error("config read returned wrong value");

  chk_read_ref: assert property (
    @(posedge ref_clk) disable iff (srst)
    (rd_en && addr == dbl_pkg::ADDR_REF) |=>
      rdata == {14'h0, $past(ref_gain_ff), $past(ref_src_ff)})
    else $error("reference read returned wrong value");

  chk_read_power: assert property (
    @(posedge ref_clk) disable iff (srst)
    (rd_en && addr == dbl_pkg::ADDR_POWER) |=> rdata == {8'h00, $past(pwr_ff)})
    else $error("power read returned wrong value");

  // the pending view is the only place the input register is visible
  chk_read_input: assert property (
    @(posedge ref_clk) disable iff (srst)
    (rd_en && addr == dbl_pkg::ADDR_INPUT0) |=> rdata == {4'h0, $past(in_q[insel_ff])})
    else $error("pending input read returned wrong value");

  chk_read_unmapped: assert property (
    @(posedge ref_clk) disable iff (srst)
    (rd_en && (addr == 4'he || addr == 4'hf || addr == dbl_pkg::ADDR_LOAD)) |=>
      rdata == dbl_pkg::RST_ZERO)
    else $error("unmapped read returned nonzero");

  // data stand one cycle only, so a late sampler sees zero, never stale data
  chk_rdata_quiet: assert property (
    @(posedge ref_clk) disable iff (srst)
    !rd_en |=> rdata == dbl_pkg::RST_ZERO)
    else $error("read data stood without a strobe");

  chk_rdata_reset: assert property (
    @(posedge ref_clk)
    srst |=> rdata == dbl_pkg::RST_ZERO)
    else $error("reset left read data set");

  // code presented to the analog side follows the latch only;
  // a powered-down channel shows zero, its latch keeps the value
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      code_ff <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        code_ff[i*DATA_W +: DATA_W] <= pwr_ff[i] ? lat_q[i] : '0;
      end
    end
  end

  // reset must leave every channel at code zero
  chk_code_reset: assert property (
    @(posedge ref_clk)
    srst |=> ch_code == '0)
    else $error("reset left a channel code set");

  assign rdata              = rdata_ff;
  assign ch_code            = code_ff;
  assign output_gain_select = gain_ff;
  assign channel_power_on   = pwr_ff;
  assign ref_source_select  = ref_src_ff;
  assign ref_gain_select    = ref_gain_ff;
  // internal reference high only when internal source and gain set
  assign int_ref_high       = int_ref_ff;

  chk_magic_load_pulse: assert property (
    @(posedge ref_clk) disable iff (srst)
    (wr_en && addr == dbl_pkg::ADDR_LOAD && wdata == dbl_pkg::LOAD_MAGIC) |-> load_event)
    else $error("magic write gave no load event");

  chk_bad_load_ignored: assert property (
    @(posedge ref_clk) disable iff (srst)
    (wr_en && addr == dbl_pkg::ADDR_LOAD && wdata != dbl_pkg::LOAD_MAGIC) |-> !int_load_pulse)
    else $error("non-magic write pulsed load");

  chk_read_latch: assert property (
    @(posedge ref_clk) disable iff (srst)
    (rd_en && addr == 4'h3) |=> rdata == {4'h0, $past(lat_q[3])})
    else $error("data read did not return latch");

  chk_power_down_zero: assert property (
    @(posedge ref_clk) disable iff (srst)
    !pwr_ff[0] |=> ch_code[DATA_W-1:0] == '0)
    else $error("powered-down channel drove code");

  chk_reset_clears: assert property (
    @(posedge ref_clk)
    srst |=> (pwr_ff == '0 && gain_ff == '0 && !ref_src_ff && !ref_gain_ff))
    else $error("reset left state set");

  chk_ref_ext_ignores: assert property (
    @(posedge ref_clk) disable iff (srst)
    ref_src_ff |-> !int_ref_high)
    else $error("external reference used reference gain");

  chk_ext_edge_loads: assert property (
    @(posedge ref_clk) disable iff (srst)
    (!ext_load_pin ##1 ext_load_pin [*3]) |-> ##[0:1] load_event)
    else $error("pin rising edge gave no load event");
endmodule

// File: dbl_host_model.sv
// host-side model: register port master and external load pin driver
`timescale 1ns/100ps
module dbl_host_model (
  input  wire logic        ref_clk,
  output logic [3:0]       addr,
  output logic [15:0]      wdata,
  output logic             wr_en,
  output logic             rd_en,
  input  wire logic [15:0] rdata,
  output logic             ext_load_pin
);
  // idle bus and a low load pin from time zero
  initial begin
    addr = 4'h0;
    wdata = 16'h0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    ext_load_pin = 1'b0;
  end
  // one-cycle write, released at the edge that takes it
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    wdata <= ~d;  // stale data must not matter once the strobe is gone
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(posedge ref_clk);
    d = rdata;
  endtask
  // pin held high long enough for the two-stage synchroniser
  task automatic pin_pulse();
    @(posedge ref_clk);
    ext_load_pin <= 1'b1;
    repeat (3) @(posedge ref_clk);
    ext_load_pin <= 1'b0;
  endtask
endmodule

// File: dbl_buffer_load_tb_top.sv
// self-checking bench for the double-buffered load control block
`timescale 1ns/100ps
module dbl_buffer_load_tb_top;
  logic        ref_clk;
  logic        srst;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        wr_en;
  logic        rd_en;
  logic [15:0] rdata;
  logic        ext_load_pin;
  logic [95:0] ch_code;
  logic [7:0]  output_gain_select;
  logic [7:0]  channel_power_on;
  logic        ref_source_select;
  logic        ref_gain_select;
  logic        int_ref_high;
  logic [15:0] rv;
  int          n_mismatch;
  int          compares;

  dbl_buffer_load dbl_buffer_load_inst (.ref_clk(ref_clk), .srst(srst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .ext_load_pin(ext_load_pin), .ch_code(ch_code), .output_gain_select(output_gain_select),
    .channel_power_on(channel_power_on), .ref_source_select(ref_source_select),
    .ref_gain_select(ref_gain_select), .int_ref_high(int_ref_high));
  dbl_host_model dbl_host_model_inst (.ref_clk(ref_clk), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .ext_load_pin(ext_load_pin));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic w(input logic [3:0] a, input logic [15:0] d);
    dbl_host_model_inst.wr(a, d);
  endtask
  task automatic r(input logic [3:0] a);
    dbl_host_model_inst.rd(a, rv);
  endtask
  // enough edges for latch and registered output to land
  task automatic settle();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic do_reset();
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic sc_reset();
    chk(ch_code, '0);
    chk({output_gain_select, channel_power_on}, '0);
    chk({ref_source_select, ref_gain_select, int_ref_high}, '0);
    r(4'h3);
    chk(rv, '0);
    r(dbl_pkg::ADDR_INPUT0);
    chk(rv, '0);
  endtask
  task automatic sc_async();
    w(dbl_pkg::ADDR_POWER, 16'h00ff);
    w(4'h3, 16'h05a5);
    settle();
    chk(ch_code, 96'h5a5 << 36);
    r(4'h3);
    chk(rv, 16'h05a5);
  endtask
  // select first, then data, then trigger; a wrong load value is ignored
  task automatic sc_sync();
    w(dbl_pkg::ADDR_CONFIG, 16'h0003);
    w(4'h0, 16'h0111);
    w(4'h1, 16'h0222);
    settle();
    chk(ch_code, 96'h5a5 << 36);
    r(4'h1);
    chk(rv, '0);
    w(dbl_pkg::ADDR_INSEL, 16'h0001);
    r(dbl_pkg::ADDR_INPUT0);
    chk(rv, 16'h0222);
    w(dbl_pkg::ADDR_LOAD, 16'hbb01);
    settle();
    chk(ch_code, 96'h5a5 << 36);
    w(dbl_pkg::ADDR_LOAD, dbl_pkg::LOAD_MAGIC);
    settle();
    chk(ch_code, (96'h5a5 << 36) | 96'h222111);
  endtask
  task automatic sc_pin();
    w(4'h0, 16'h0abc);
    w(4'h3, 16'h0333);
    settle();
    chk(ch_code, (96'h333 << 36) | 96'h222111);
    dbl_host_model_inst.pin_pulse();
    settle();
    chk(ch_code, (96'h333 << 36) | 96'h222abc);
  endtask
  task automatic sc_gain_ref();
    w(dbl_pkg::ADDR_CONFIG, 16'ha503);
    settle();
    chk(output_gain_select, 8'ha5);
    r(dbl_pkg::ADDR_CONFIG);
    chk(rv, 16'ha503);
    for (int i = 0; i < 4; i++) begin
      w(dbl_pkg::ADDR_REF, 16'(i));
      settle();
      chk({ref_source_select, ref_gain_select, int_ref_high}, {i[0], i[1], i == 2});
    end
    r(dbl_pkg::ADDR_REF);
    chk(rv, 16'h0003);
  endtask
  // near-zero output comes from the power bit, not from code zero
  task automatic sc_power();
    w(dbl_pkg::ADDR_POWER, 16'h00f7);
    settle();
    chk(ch_code, 96'h222abc);
    chk(channel_power_on, 8'hf7);
    w(4'h3, 16'h0444);
    settle();
    chk(ch_code, 96'h222abc);
    w(dbl_pkg::ADDR_POWER, 16'h00ff);
    settle();
    chk(ch_code, (96'h444 << 36) | 96'h222abc);
    r(4'he);
    chk(rv, '0);
    r(dbl_pkg::ADDR_POWER);
    chk(rv, 16'h00ff);
  endtask
  task automatic print_verdict();
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    srst = 1'b1;
    n_mismatch = 0;
    compares = 0;
    do_reset();
    sc_reset();
    sc_async();
    sc_sync();
    sc_pin();
    sc_gain_ref();
    sc_power();
    do_reset();
    sc_reset();
    print_verdict();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    print_verdict();
  end
endmodule
